// ---- rtl/mie_core.sv ----
// instruction sequencing and execution timing of the 8-bit core
// Operation
// - every instruction cycle is four system clocks; timing counts these cycles
// - ordinary ops take one cycle; jump, call, returns, table read take two
// - writing the program counter low byte jumps there, one extra cycle
// - skip tests take one cycle, or two when the skip is taken
// - conditional skips test a byte or one bit, then run or skip next
// - call saves the next address, exit resumes there, jump saves nothing
// - add reports carry above 255, subtract reports borrow below 0
// - increment and decrement change by one, result to memory or accumulator
// - logic ops and invert set the zero flag on a zero result
// - rotates move one bit; carry variants swap bit out with carry
// - bit set and clear change one bit, others kept by read-modify-write
// - three moves: memory to acc, acc to memory, immediate to acc
// - table read fetches constant data from program memory
`default_nettype none
module mie_core
  import mie_pkg::*;
#(
  parameter int STACK_DEPTH = STACK_DEPTH_DEF
)(
  // clock and reset
  input  wire logic               SYS_CLK,
  input  wire logic               RST_N,
  // program memory
  output logic [PC_W-1:0]         PROG_ADDR,
  input  wire logic [INSTR_W-1:0] PROG_DATA,
  // data memory
  output logic [7:0]              DATA_ADDR,
  input  wire logic [7:0]         DATA_RDATA,
  output logic [7:0]              DATA_WDATA,
  output logic                    DATA_WE,
  // core state
  output logic [7:0]              ACC,
  output logic                    FLAG_C,
  output logic                    FLAG_Z,
  output logic [7:0]              TBL_HIGH,
  output logic                    INSTR_DONE
);
  localparam int SP_W = $clog2(STACK_DEPTH);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync;
  logic       rst_n_s;

  // asynchronous assert, release after two clocks
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) rst_sync <= 2'b00;
    else        rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n_s = rst_sync[1];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  mie_phase_t         phase;
  logic [PC_W-1:0]    pc;
  logic [INSTR_W-1:0] ir;
  logic [7:0]         mdr;
  logic               bubble;      // second cycle of a two-cycle instruction
  logic               tbl_pend;    // bubble carries a table fetch
  logic [PC_W-1:0]    stk [STACK_DEPTH];
  logic [SP_W-1:0]    sp;

  // decode
  logic [4:0]      op;
  logic [2:0]      fld;
  logic [7:0]      opr;
  logic            dest_grp;
  logic            imm_form;
  logic            wr_mem;
  logic            wr_acc;
  logic            skip_cond;
  logic [7:0]      alu_b;
  logic [7:0]      alu_y;
  logic            alu_c;
  logic            alu_z;
  logic            alu_upd_c;
  logic            alu_upd_z;
  logic [PC_W-1:0] next_pc;
  logic            next_bubble;
  logic            next_tbl;
  logic            push;
  logic            pop;
  logic [PC_W-1:0] tbl_addr;

  assign op        = ir[OP_HI:OP_LO];
  assign fld       = ir[FLD_HI:FLD_LO];
  assign opr       = ir[7:0];
  assign dest_grp  = (op >= OP_ADD) && (op <= OP_ROTLC);
  assign imm_form  = (op == OP_MOVAI) || (fld[FLD_IMM] && (op >= OP_ADD) && (op <= OP_XOR));
  assign alu_b     = imm_form ? opr : mdr;
  assign tbl_addr  = {TBL_PAGE, ACC};
  assign DATA_ADDR = opr;

  // memory and accumulator destinations
  assign wr_mem = (op == OP_MOVMA) || (op == OP_SETB) || (op == OP_CLRB)
               || (op == OP_CLRM) || (dest_grp && fld[FLD_DEST_MEM] && !imm_form);
  assign wr_acc = (op == OP_MOVAM) || (op == OP_MOVAI)
               || (dest_grp && !(fld[FLD_DEST_MEM] && !imm_form));

  // byte and bit tests of the conditional skips
  always_comb begin
    case (op)
      OP_SZ:   skip_cond = (mdr == 8'h00);
      OP_SNZ:  skip_cond = (mdr != 8'h00);
      OP_SBZ:  skip_cond = !mdr[fld];
      OP_SBNZ: skip_cond = mdr[fld];
      default: skip_cond = 1'b0;
    endcase
  end

  mie_alu u_alu (
    .op      (op),
    .bit_sel (fld),
    .a       (ACC),
    .b       (alu_b),
    .c_in    (FLAG_C),
    .y       (alu_y),
    .c_out   (alu_c),
    .z_out   (alu_z),
    .upd_c   (alu_upd_c),
    .upd_z   (alu_upd_z)
  );

  // ----------------------------------------------------------------
  // next program counter and extra cycle
  // ----------------------------------------------------------------
  always_comb begin
    next_pc     = pc + 11'h001;
    next_bubble = 1'b0;
    next_tbl    = 1'b0;
    push        = 1'b0;
    pop         = 1'b0;
    if (bubble) begin
      next_pc = pc;                      // target already loaded
    end else begin
      case (op)
        OP_JUMP: begin
          next_pc     = {fld, opr};      // no return address kept
          next_bubble = 1'b1;
        end
        OP_CALL: begin
          next_pc     = {fld, opr};
          next_bubble = 1'b1;
          push        = 1'b1;
        end
        OP_SUBX, OP_INTX: begin
          next_pc     = stk[SP_W'(sp - 1'b1)];
          next_bubble = 1'b1;
          pop         = 1'b1;
        end
        OP_TABRD: begin
          next_bubble = 1'b1;
          next_tbl    = 1'b1;
        end
        OP_SZ, OP_SNZ, OP_SBZ, OP_SBNZ: begin
          if (skip_cond) begin
            next_pc     = pc + 11'h002;
            next_bubble = 1'b1;
          end
        end
        default: begin
          if (wr_mem && (opr == PC_LOW_ADDR)) begin
            next_pc     = {pc[PC_W-1:8], alu_y};
            next_bubble = 1'b1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // phase sequencing
  // ----------------------------------------------------------------
  // four clocks per instruction cycle, no stall
  always_ff @(posedge SYS_CLK or negedge rst_n_s) begin
    if (!rst_n_s) phase <= PH_FETCH;
    else begin
      case (phase)
        PH_FETCH: phase <= PH_READ;
        PH_READ:  phase <= PH_EXEC;
        PH_EXEC:  phase <= PH_WRITE;
        PH_WRITE: phase <= PH_FETCH;
        default:  phase <= PH_FETCH;
      endcase
    end
  end

  // program counter, extra-cycle marker and fetch address
  always_ff @(posedge SYS_CLK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      pc        <= '0;
      bubble    <= 1'b0;
      tbl_pend  <= 1'b0;
      PROG_ADDR <= '0;
    end else if (phase == PH_WRITE) begin
      pc        <= next_pc;
      bubble    <= next_bubble;
      tbl_pend  <= next_tbl;
      PROG_ADDR <= next_pc;
    end else if (phase == PH_FETCH && bubble && tbl_pend) begin
      PROG_ADDR <= tbl_addr;             // table word read in the spare cycle
    end else if (phase == PH_READ && !(bubble && tbl_pend)) begin
      PROG_ADDR <= pc;                   // table address held so the low byte is read too
    end
  end

  // instruction and operand latches; ir holds through a spare cycle
  always_ff @(posedge SYS_CLK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      ir       <= '0;
      mdr      <= 8'h00;
      TBL_HIGH <= 8'h00;
    end else begin
      if (phase == PH_FETCH && !bubble) ir <= PROG_DATA;
      if (phase == PH_READ) mdr <= DATA_RDATA;
      if (phase == PH_READ && bubble && tbl_pend) TBL_HIGH <= PROG_DATA[15:8];
    end
  end

  // data memory write strobe stands through the write phase
  always_ff @(posedge SYS_CLK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      DATA_WE    <= 1'b0;
      DATA_WDATA <= 8'h00;
      INSTR_DONE <= 1'b0;
    end else if (phase == PH_EXEC) begin
      DATA_WE    <= bubble ? tbl_pend : wr_mem;
      DATA_WDATA <= (bubble && tbl_pend) ? PROG_DATA[7:0] : alu_y;
      INSTR_DONE <= !next_bubble;
    end else begin
      DATA_WE    <= 1'b0;
      INSTR_DONE <= 1'b0;
    end
  end

  // accumulator and flags change only at the end of a working cycle
  always_ff @(posedge SYS_CLK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      ACC    <= 8'h00;
      FLAG_C <= 1'b0;
      FLAG_Z <= 1'b0;
    end else if (phase == PH_WRITE && !bubble) begin
      if (wr_acc)    ACC    <= alu_y;
      if (alu_upd_c) FLAG_C <= alu_c;
      if (alu_upd_z) FLAG_Z <= alu_z;
    end
  end

  // return stack; overflow wraps, as on small cores without a trap
  always_ff @(posedge SYS_CLK or negedge rst_n_s) begin
    if (!rst_n_s) sp <= '0;
    else if (phase == PH_WRITE && push) sp <= SP_W'(sp + 1'b1);
    else if (phase == PH_WRITE && pop)  sp <= SP_W'(sp - 1'b1);
  end

  // stack contents need no reset
  always_ff @(posedge SYS_CLK) begin
    if (phase == PH_WRITE && push) stk[sp] <= pc + 11'h001;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_cycle;
    phase == PH_READ ##1 phase == PH_EXEC ##1 phase == PH_WRITE ##1 phase == PH_FETCH;
  endsequence
  property p_cycle;
    @(posedge SYS_CLK) disable iff (!rst_n_s) phase == PH_FETCH |=> s_cycle;
  endproperty
  a_cycle: assert property (p_cycle) else $error("phase order broken");

  property p_done_spacing;
    @(posedge SYS_CLK) disable iff (!rst_n_s) INSTR_DONE |=> !INSTR_DONE [*3];
  endproperty
  a_done_spacing: assert property (p_done_spacing) else $error("done too close");

  sequence s_spare;
    bubble [*4] ##1 !bubble;
  endsequence
  property p_two_cycle;
    @(posedge SYS_CLK) disable iff (!rst_n_s)
      (phase == PH_WRITE && !bubble && (op == OP_JUMP || op == OP_CALL || op == OP_SUBX
       || op == OP_INTX || op == OP_TABRD)) |=> s_spare;
  endproperty
  a_two_cycle: assert property (p_two_cycle) else $error("missing spare cycle");

  property p_pcl_write;
    @(posedge SYS_CLK) disable iff (!rst_n_s)
      (phase == PH_WRITE && !bubble && DATA_WE && DATA_ADDR == PC_LOW_ADDR)
      |=> bubble && pc == {$past(pc[PC_W-1:8]), $past(DATA_WDATA)};
  endproperty
  a_pcl_write: assert property (p_pcl_write) else $error("low byte write no jump");

  property p_skip_taken;
    @(posedge SYS_CLK) disable iff (!rst_n_s)
      (phase == PH_WRITE && !bubble && op >= OP_SZ && op <= OP_SBNZ && skip_cond)
      |=> bubble && pc == $past(pc) + 11'h002;
  endproperty
  a_skip_taken: assert property (p_skip_taken) else $error("skip not taken");

  property p_skip_not;
    @(posedge SYS_CLK) disable iff (!rst_n_s)
      (phase == PH_WRITE && !bubble && op >= OP_SZ && op <= OP_SBNZ && !skip_cond)
      |=> !bubble && pc == $past(pc) + 11'h001;
  endproperty
  a_skip_not: assert property (p_skip_not) else $error("skip cost wrong");

  property p_call_save;
    @(posedge SYS_CLK) disable iff (!rst_n_s)
      (phase == PH_WRITE && !bubble && op == OP_CALL)
      |=> stk[SP_W'(sp - 1'b1)] == $past(pc) + 11'h001;
  endproperty
  a_call_save: assert property (p_call_save) else $error("return address wrong");

  property p_add_carry;
    @(posedge SYS_CLK) disable iff (!rst_n_s)
      (phase == PH_WRITE && !bubble && op == OP_ADD)
      |=> FLAG_C == (({1'b0, $past(ACC)} + {1'b0, $past(alu_b)}) > 9'h0FF);
  endproperty
  a_add_carry: assert property (p_add_carry) else $error("carry wrong");

  property p_bit_set;
    @(posedge SYS_CLK) disable iff (!rst_n_s)
      (phase == PH_WRITE && !bubble && op == OP_SETB)
      |-> DATA_WE && DATA_WDATA == (mdr | (8'h01 << fld));
  endproperty
  a_bit_set: assert property (p_bit_set) else $error("bit set wrong");

  property p_logic_zero;
    @(posedge SYS_CLK) disable iff (!rst_n_s)
      (phase == PH_WRITE && !bubble && op == OP_AND)
      |=> FLAG_Z == (($past(ACC) & $past(alu_b)) == 8'h00);
  endproperty
  a_logic_zero: assert property (p_logic_zero) else $error("zero flag wrong");
endmodule
`default_nettype wire

// ---- rtl/mie_pkg.sv ----
// package: instruction encoding, phases and timing constants of the core
`default_nettype none
package mie_pkg;
  // ----------------------------------------------------------------
  // widths and timing
  // ----------------------------------------------------------------
  localparam int CYCLE_CLKS = 4;           // system clocks per instruction cycle
  localparam int PC_W       = 11;
  localparam int INSTR_W    = 16;
  localparam int DATA_W     = 8;
  localparam int STACK_DEPTH_DEF = 8;
  // ----------------------------------------------------------------
  // instruction fields: [15:11] op, [10:8] field, [7:0] operand
  // ----------------------------------------------------------------
  localparam int OP_HI  = 15;
  localparam int OP_LO  = 11;
  localparam int FLD_HI = 10;
  localparam int FLD_LO = 8;
  localparam int FLD_DEST_MEM = 0;          // field bit: result to data memory
  localparam int FLD_IMM      = 1;          // field bit: operand is immediate
  // data memory address that aliases the program counter low byte
  localparam logic [7:0] PC_LOW_ADDR = 8'h06;
  // page of program memory holding constant tables
  localparam logic [2:0] TBL_PAGE = 3'h7;
  // ----------------------------------------------------------------
  // opcodes; OP_ADD..OP_ROTLC form the destination-selectable group
  // ----------------------------------------------------------------
  localparam logic [4:0] OP_NOP   = 5'h00;
  localparam logic [4:0] OP_MOVAM = 5'h01;  // transfer_op memory to acc
  localparam logic [4:0] OP_MOVMA = 5'h02;  // transfer_op acc to memory
  localparam logic [4:0] OP_MOVAI = 5'h03;  // transfer_op immediate to acc
  localparam logic [4:0] OP_ADD   = 5'h04;
  localparam logic [4:0] OP_ADC   = 5'h05;
  localparam logic [4:0] OP_SUB   = 5'h06;
  localparam logic [4:0] OP_SBC   = 5'h07;
  localparam logic [4:0] OP_AND   = 5'h08;
  localparam logic [4:0] OP_OR    = 5'h09;
  localparam logic [4:0] OP_XOR   = 5'h0A;
  localparam logic [4:0] OP_INV   = 5'h0B;  // bitwise_invert
  localparam logic [4:0] OP_INC   = 5'h0C;  // add_one_to_acc / memory
  localparam logic [4:0] OP_DECR  = 5'h0D;  // subtract_one_memory / to_acc
  localparam logic [4:0] OP_ROTR  = 5'h0E;  // rotate_right
  localparam logic [4:0] OP_ROTL  = 5'h0F;  // rotate_left
  localparam logic [4:0] OP_ROTRC = 5'h10;  // rotate_right_via_carry
  localparam logic [4:0] OP_ROTLC = 5'h11;  // rotate_left_via_carry
  localparam logic [4:0] OP_SETB  = 5'h12;
  localparam logic [4:0] OP_CLRB  = 5'h13;
  localparam logic [4:0] OP_CLRM  = 5'h14;
  localparam logic [4:0] OP_SZ    = 5'h15;  // skip if byte is zero
  localparam logic [4:0] OP_SNZ   = 5'h16;  // skip if byte is not zero
  localparam logic [4:0] OP_SBZ   = 5'h17;  // skip if bit is clear
  localparam logic [4:0] OP_SBNZ  = 5'h18;  // skip if bit is set
  localparam logic [4:0] OP_JUMP  = 5'h19;  // unconditional_jump
  localparam logic [4:0] OP_CALL  = 5'h1A;
  localparam logic [4:0] OP_SUBX  = 5'h1B;  // subroutine_exit
  localparam logic [4:0] OP_INTX  = 5'h1C;  // interrupt_exit
  localparam logic [4:0] OP_TABRD = 5'h1D;
  // ----------------------------------------------------------------
  // phases of one instruction cycle
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PH_FETCH, PH_READ, PH_EXEC, PH_WRITE} mie_phase_t;
endpackage
`default_nettype wire

// ---- rtl/mie_alu.sv ----
// 8-bit arithmetic, logic, rotate and bit unit of the core
`default_nettype none
module mie_alu
  import mie_pkg::*;
(
  // operation
  input  wire logic [4:0] op,
  input  wire logic [2:0] bit_sel,
  // operands
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic       c_in,
  // result
  output logic [7:0]      y,
  output logic            c_out,
  output logic            z_out,
  output logic            upd_c,
  output logic            upd_z
);
  logic [8:0] wide;
  logic [7:0] mask;

  // one-hot bit mask for the single-bit forms
  assign mask = 8'h01 << bit_sel;

  // result and flag selection; 9-bit sums keep the carry or borrow
  always_comb begin
    wide  = 9'h000;
    y     = 8'h00;
    c_out = c_in;
    upd_c = 1'b0;
    upd_z = 1'b0;
    case (op)
      OP_MOVAM, OP_MOVAI: y = b;
      OP_MOVMA:           y = a;
      OP_ADD, OP_ADC: begin
        wide  = {1'b0, a} + {1'b0, b} + {8'h00, (op == OP_ADC) & c_in};
        y     = wide[7:0];
        c_out = wide[8];
        upd_c = 1'b1;
        upd_z = 1'b1;
      end
      OP_SUB, OP_SBC: begin
        wide  = {1'b0, a} - {1'b0, b} - {8'h00, (op == OP_SBC) & c_in};
        y     = wide[7:0];
        c_out = wide[8];                     // borrow out
        upd_c = 1'b1;
        upd_z = 1'b1;
      end
      OP_AND: begin y = a & b; upd_z = 1'b1; end
      OP_OR:  begin y = a | b; upd_z = 1'b1; end
      OP_XOR: begin y = a ^ b; upd_z = 1'b1; end
      OP_INV: begin y = ~b;    upd_z = 1'b1; end
      OP_INC: begin y = b + 8'h01; upd_z = 1'b1; end
      OP_DECR: begin y = b - 8'h01; upd_z = 1'b1; end
      OP_ROTR: y = {b[0], b[7:1]};
      OP_ROTL: y = {b[6:0], b[7]};
      OP_ROTRC: begin y = {c_in, b[7:1]}; c_out = b[0]; upd_c = 1'b1; end
      OP_ROTLC: begin y = {b[6:0], c_in}; c_out = b[7]; upd_c = 1'b1; end
      OP_SETB: y = b | mask;
      OP_CLRB: y = b & ~mask;
      OP_CLRM: y = 8'h00;
      default: y = 8'h00;
    endcase
  end

  assign z_out = (y == 8'h00);
endmodule
`default_nettype wire

// ---- verification/mie_core_tb.sv ----
// self-checking bench for the instruction sequencing core
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import mie_pkg::*;

  // ----------------------------------------------------------------
  // signals, memories and expectation rows
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] acc;
    logic       c;
    logic       z;
    logic [7:0] clks;
  } mie_row_t;

  localparam int N_ROWS = 33;
  logic               SYS_CLK = 1'b0;
  logic               RST_N   = 1'b0;
  logic [PC_W-1:0]    PROG_ADDR;
  logic [INSTR_W-1:0] PROG_DATA;
  logic [7:0]         DATA_ADDR;
  logic [7:0]         DATA_RDATA;
  logic [7:0]         DATA_WDATA;
  logic               DATA_WE;
  logic [7:0]         ACC;
  logic               FLAG_C;
  logic               FLAG_Z;
  logic [7:0]         TBL_HIGH;
  logic               INSTR_DONE;
  logic [INSTR_W-1:0] prog [0:2047];
  logic [7:0]         dmem [0:255];
  logic [INSTR_W-1:0] code [29];
  mie_row_t           rows [N_ROWS];
  int                 n_fail = 0;
  int                 n_tests = 0;
  int                 n_clk;

  mie_core #(
    .STACK_DEPTH (STACK_DEPTH_DEF)
  ) i_dut (
    .SYS_CLK    (SYS_CLK),
    .RST_N      (RST_N),
    .PROG_ADDR  (PROG_ADDR),
    .PROG_DATA  (PROG_DATA),
    .DATA_ADDR  (DATA_ADDR),
    .DATA_RDATA (DATA_RDATA),
    .DATA_WDATA (DATA_WDATA),
    .DATA_WE    (DATA_WE),
    .ACC        (ACC),
    .FLAG_C     (FLAG_C),
    .FLAG_Z     (FLAG_Z),
    .TBL_HIGH   (TBL_HIGH),
    .INSTR_DONE (INSTR_DONE)
  );

  // 100 MHz system clock
  initial begin
    forever #5 SYS_CLK = ~SYS_CLK;
  end

  // asynchronous reads; the write lands on the edge that ends the strobe
  assign PROG_DATA  = prog[PROG_ADDR];
  assign DATA_RDATA = dmem[DATA_ADDR];
  always @(posedge SYS_CLK) begin
    if (DATA_WE === 1'b1) begin
      dmem[DATA_ADDR] <= DATA_WDATA;
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] ins(input logic [4:0] op, input logic [2:0] fld,
                                      input logic [7:0] opd);
    return {op, fld, opd};
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // counts clocks up to the next completion pulse, then steps past its edge
  task automatic wait_done();
    n_clk = 0;
    do begin
      @(negedge SYS_CLK);
      n_clk++;
    end while (INSTR_DONE !== 1'b1 && n_clk < 40);
    chk(16'(INSTR_DONE), 16'h0001);
    @(posedge SYS_CLK);
    #1;
  endtask

  task automatic chk_reset();
    chk({ACC, TBL_HIGH}, 16'h0000);
    chk(16'(PROG_ADDR), 16'h0000);
    chk({DATA_WDATA, 4'h0, FLAG_C, FLAG_Z, DATA_WE, INSTR_DONE}, 16'h0000);
  endtask

  task automatic close_out();
    if (n_fail == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // hang guard, far beyond the few hundred cycles the program needs
  initial begin
    #(5000 * 10);
    n_fail++;
    close_out();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    code = '{ins(OP_MOVAI, 3'h0, 8'hF0), ins(OP_ADD, 3'h2, 8'h20), ins(OP_ADC, 3'h0, 8'h11),
             ins(OP_SUB, 3'h2, 8'h40), ins(OP_SBC, 3'h0, 8'h12), ins(OP_AND, 3'h2, 8'h00),
             ins(OP_OR, 3'h2, 8'h55), ins(OP_XOR, 3'h0, 8'h13), ins(OP_INV, 3'h0, 8'h13),
             ins(OP_INC, 3'h0, 8'h12), ins(OP_DECR, 3'h1, 8'h12), ins(OP_ROTRC, 3'h0, 8'h13),
             ins(OP_ROTLC, 3'h0, 8'h13), ins(OP_ROTR, 3'h0, 8'h10), ins(OP_ROTL, 3'h0, 8'h13),
             ins(OP_SETB, 3'h3, 8'h14), ins(OP_CLRB, 3'h7, 8'h10), ins(OP_MOVAM, 3'h0, 8'h10),
             ins(OP_MOVMA, 3'h0, 8'h15), ins(OP_SZ, 3'h0, 8'h16), ins(OP_MOVAI, 3'h0, 8'hEE),
             ins(OP_SNZ, 3'h0, 8'h16), ins(OP_SBNZ, 3'h0, 8'h13), ins(OP_MOVAI, 3'h0, 8'hEE),
             ins(OP_SBZ, 3'h0, 8'h13), ins(OP_CALL, 3'h0, 8'h40), ins(OP_TABRD, 3'h0, 8'h17),
             ins(OP_MOVAI, 3'h0, 8'h30), ins(OP_MOVMA, 3'h0, PC_LOW_ADDR)};
    // acc, carry, zero, clocks since the previous completion (0: not checked)
    rows = '{'{8'hF0, 1'b0, 1'b0, 8'h00}, '{8'h10, 1'b1, 1'b0, 8'h04}, '{8'h31, 1'b0, 1'b0, 8'h04},
             '{8'hF1, 1'b1, 1'b0, 8'h04}, '{8'hF0, 1'b0, 1'b0, 8'h04}, '{8'h00, 1'b0, 1'b1, 8'h04},
             '{8'h55, 1'b0, 1'b0, 8'h04}, '{8'h00, 1'b0, 1'b1, 8'h04}, '{8'hAA, 1'b0, 1'b0, 8'h04},
             '{8'h01, 1'b0, 1'b0, 8'h04}, '{8'h01, 1'b0, 1'b0, 8'h04}, '{8'h2A, 1'b1, 1'b0, 8'h04},
             '{8'hAB, 1'b0, 1'b0, 8'h04}, '{8'h78, 1'b0, 1'b0, 8'h04}, '{8'hAA, 1'b0, 1'b0, 8'h04},
             '{8'hAA, 1'b0, 1'b0, 8'h04}, '{8'hAA, 1'b0, 1'b0, 8'h04}, '{8'h70, 1'b0, 1'b0, 8'h04},
             '{8'h70, 1'b0, 1'b0, 8'h04}, '{8'h70, 1'b0, 1'b0, 8'h08}, '{8'h70, 1'b0, 1'b0, 8'h04},
             '{8'h70, 1'b0, 1'b0, 8'h08}, '{8'h70, 1'b0, 1'b0, 8'h04}, '{8'h70, 1'b0, 1'b0, 8'h08},
             '{8'h3C, 1'b0, 1'b0, 8'h04}, '{8'h3C, 1'b0, 1'b0, 8'h08}, '{8'h3C, 1'b0, 1'b0, 8'h08},
             '{8'h30, 1'b0, 1'b0, 8'h04}, '{8'h30, 1'b0, 1'b0, 8'h08}, '{8'h30, 1'b0, 1'b0, 8'h08},
             '{8'h30, 1'b0, 1'b0, 8'h08}, '{8'h30, 1'b0, 1'b0, 8'h08}, '{8'h81, 1'b0, 1'b0, 8'h04}};
    // unused words jump to themselves so a stray pc parks instead of running on
    for (int a = 0; a < 2048; a++) prog[a] = ins(OP_JUMP, a[10:8], a[7:0]);
    for (int a = 0; a < 29; a++) prog[a] = code[a];
    prog[11'h030] = ins(OP_JUMP, 3'h0, 8'h50);
    prog[11'h040] = ins(OP_MOVAI, 3'h0, 8'h3C);
    prog[11'h041] = ins(OP_SUBX, 3'h0, 8'h00);
    prog[11'h050] = ins(OP_CALL, 3'h0, 8'h60);
    prog[11'h051] = ins(OP_MOVAI, 3'h0, 8'h81);
    prog[11'h052] = ins(OP_CLRM, 3'h0, PC_LOW_ADDR);
    prog[11'h060] = ins(OP_INTX, 3'h0, 8'h00);
    prog[{TBL_PAGE, 8'h3C}] = 16'h9A5B;
    for (int a = 0; a < 256; a++) dmem[a] = 8'h00;
    dmem[8'h10] = 8'hF0;
    dmem[8'h11] = 8'h20;
    dmem[8'h13] = 8'h55;
    repeat (10) @(posedge SYS_CLK);
    #1;
    chk_reset();
    @(posedge SYS_CLK);
    RST_N <= 1'b1;
    // one row per completed instruction
    for (int i = 0; i < N_ROWS; i++) begin
      wait_done();
      chk(16'(ACC), 16'(rows[i].acc));
      chk(16'(FLAG_C), 16'(rows[i].c));
      chk(16'(FLAG_Z), 16'(rows[i].z));
      if (rows[i].clks != 8'h00) begin
        chk(16'(n_clk), 16'(rows[i].clks));
      end
    end
    // clearing the low byte restarts the program at address zero
    wait_done();
    chk(16'(n_clk), 16'h0008);
    wait_done();
    chk(16'(ACC), 16'h00F0);
    // memory side effects of the run
    chk(16'(dmem[8'h12]), 16'h00FF);
    chk({dmem[8'h14], dmem[8'h10]}, 16'h0870);
    chk(16'(dmem[8'h15]), 16'h0070);
    chk({TBL_HIGH, dmem[8'h17]}, 16'h9A5B);
    // reset in mid-run, then the program restarts from address zero
    @(posedge SYS_CLK);
    RST_N <= 1'b0;
    @(posedge SYS_CLK);
    #1;
    chk_reset();
    repeat (10) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    wait_done();
    chk(16'(ACC), 16'h00F0);
    close_out();
  end
endmodule
`default_nettype wire
